// file: shared/hwfs_pkg.sv
package hwfs_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned QOFF_MIN_US     = 1000;
    // Least low time rounds up to whole cycles.
    // One microsecond is 1000000 ps, so 1 ms at a 5 ns clock is 200000 cycles.
    localparam int unsigned QOFF_MIN_CYC    =
        (QOFF_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W           = 20;
    // Flash-settle length in cycles; no state uses it, as HWFS_FLUSH waits on flash_busy alone.
    localparam int unsigned FLASH_DONE_CYC  = 16;
    localparam int unsigned FLASH_W         = 5;

    // ************************************************************
    // Pad function codes and reset values
    // ************************************************************
    localparam logic [1:0] PAD_FN_GPIO      = 2'h0;
    localparam logic [1:0] PAD_FN_QUICK_OFF = 2'h1;
    localparam logic [1:0] PAD_FN_RESET     = 2'h0;
    localparam logic       WAKE_IDLE        = 1'h1;
    localparam logic       WAKE_ACTIVE      = 1'h0;

    // ************************************************************
    // Power sequencer states, Gray coded along the usual path
    // ************************************************************
    typedef enum logic [2:0] {
        HWFS_ACTIVE   = 3'h0,
        HWFS_FLUSH    = 3'h1,
        HWFS_DEREG    = 3'h3,
        HWFS_OFF      = 3'h2
    } hwfs_state_type;

endpackage : hwfs_pkg

// file: shared/hwfs_if.sv
`timescale 1ns/10ps
// Pins between the module and the host; pull-up on the pad resolved here.
interface hwfs_if;
    logic host_wake_line;     // Module to host, active low wake request.
    logic power_ind;          // Module to host, low while active.
    logic on_line;            // Host to module power-on input.
    logic quick_off_o;        // Host drive value of the shutdown pad.
    logic quick_off_oe;       // Host drive enable of the shutdown pad.
    logic pad_pullup_en;      // Module applies internal pull-up.
    logic quick_off_line;     // Resolved pad level.

    // Undriven pad floats to the pull-up level, or low when no pull-up.
    assign quick_off_line = quick_off_oe ? quick_off_o : pad_pullup_en;

    modport module_end (output host_wake_line, output power_ind, output pad_pullup_en,
                        input on_line, input quick_off_line);
    modport host_end (input host_wake_line, input power_ind, output on_line,
                      output quick_off_o, output quick_off_oe);
endinterface : hwfs_if

// file: src/hwfs_module.sv
`timescale 1ns/10ps

module hwfs_module #(
    parameter int unsigned QOFF_CYC = hwfs_pkg::QOFF_MIN_CYC // Low-time threshold in cycles.
) (
    input  wire logic      clk,              // 200 MHz clock.
    input  wire logic      srst,             // Synchronous reset, high.
    hwfs_if.module_end     pins,             // Pins toward the host.
    input  wire logic [1:0] cfg_pad_fn,      // Stored pad function for next restart.
    input  wire logic      cfg_pad_fn_we,    // Pulse: store cfg_pad_fn.
    input  wire logic      arm_quick_off,    // Pulse: shutdown command arms pad.
    input  wire logic      cmd_shutdown,     // Pulse: shutdown command.
    input  wire logic      cmd_fast,         // With cmd_shutdown: fast option.
    input  wire logic      event_pending,    // Incoming call, message or report.
    input  wire logic      host_awake,       // Host interface is up.
    input  wire logic      flash_busy,       // Flash file system still writing.
    input  wire logic      dereg_done,       // Network deregistration finished.
    output logic           report_pulse,     // Pulse: shutdown report emitted.
    output logic           dereg_req,        // Level: deregistration under way.
    output logic [1:0]     pad_fn_active,    // Pad function now in force.
    output logic           powered_down      // Level: module is off.
);
    import hwfs_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    hwfs_state_type         state_r, state_nxt;
    logic [1:0]             fn_store_r, fn_store_nxt;
    logic [1:0]             fn_act_r, fn_act_nxt;
    logic                   armed_r, armed_nxt;
    logic                   sync1_r, sync2_r;
    logic [CNT_W-1:0]       low_cnt_r, low_cnt_nxt;
    logic                   fast_r, fast_nxt;
    logic                   wake_r, wake_nxt;
    logic                   pwr_r, pwr_nxt;
    logic                   rep_r, rep_nxt;
    logic                   pull_r, pull_nxt;
    logic                   dereg_r, dereg_nxt;

    // Two flops before the pad level is used; the first feeds only the second.
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r <= 1'h1;
            sync2_r <= 1'h1;
        end else begin
            sync1_r <= pins.quick_off_line;
            sync2_r <= sync1_r;
        end
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Everything funnels through one process so the sequencer sees a consistent view.
    always_comb begin
        state_nxt    = state_r;
        fn_store_nxt = fn_store_r;
        fn_act_nxt   = fn_act_r;
        armed_nxt    = armed_r;
        low_cnt_nxt  = low_cnt_r;
        fast_nxt     = fast_r;
        wake_nxt     = wake_r;
        rep_nxt      = 1'h0;
        // New pad function is only stored; it takes effect at the next restart.
        if (cfg_pad_fn_we) begin
            fn_store_nxt = cfg_pad_fn;
        end
        if (arm_quick_off && fn_act_r == PAD_FN_QUICK_OFF) begin
            armed_nxt = 1'h1;
        end
        // Count low time; the counter saturates so long holds cannot wrap.
        if (sync2_r || fn_act_r != PAD_FN_QUICK_OFF) begin
            low_cnt_nxt = '0;
        end else if (low_cnt_r != CNT_W'(QOFF_CYC + 1)) begin
            low_cnt_nxt = low_cnt_r + CNT_W'(1);
        end
        // Wake request: held low in HWFS_ACTIVE while an event waits and the host sleeps.
        if (state_r == HWFS_ACTIVE && event_pending && !host_awake) begin
            wake_nxt = WAKE_ACTIVE;
        end else begin
            wake_nxt = WAKE_IDLE;
        end
        case (state_r)
            HWFS_ACTIVE: begin
                // Strictly longer than 1 ms counts as a valid request.
                if (armed_r && low_cnt_r > CNT_W'(QOFF_CYC)) begin
                    fast_nxt  = 1'h1;
                    state_nxt = HWFS_FLUSH;
                end else if (cmd_shutdown) begin
                    fast_nxt  = cmd_fast;
                    rep_nxt   = !cmd_fast;
                    state_nxt = HWFS_FLUSH;
                end
            end
            HWFS_FLUSH: begin
                // Flash is always finished to keep the file system intact.
                if (!flash_busy) begin
                    state_nxt = fast_r ? HWFS_OFF : HWFS_DEREG;
                end
            end
            HWFS_DEREG: begin
                if (dereg_done) begin
                    state_nxt = HWFS_OFF;
                end
            end
            HWFS_OFF: begin
                state_nxt = HWFS_OFF;
            end
            default: begin
                state_nxt = HWFS_OFF;
            end
        endcase
        pwr_nxt  = (state_nxt == HWFS_OFF);
        pull_nxt = (fn_act_r == PAD_FN_QUICK_OFF);
        // Registered so the deregistration output comes straight from a flop.
        dereg_nxt = (state_nxt == HWFS_DEREG);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Restart (srst) loads the stored pad function into the active one.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r    <= HWFS_ACTIVE;
            fn_act_r   <= fn_store_r;
            armed_r    <= 1'h0;
            low_cnt_r  <= '0;
            fast_r     <= 1'h0;
            wake_r     <= WAKE_IDLE;
            pwr_r      <= 1'h0;
            rep_r      <= 1'h0;
            // Pull-up follows the stored function in reset, so the pad shows no false low.
            pull_r     <= (fn_store_r == PAD_FN_QUICK_OFF);
            dereg_r    <= 1'h0;
        end else begin
            state_r    <= state_nxt;
            fn_act_r   <= fn_act_nxt;
            armed_r    <= armed_nxt;
            low_cnt_r  <= low_cnt_nxt;
            fast_r     <= fast_nxt;
            wake_r     <= wake_nxt;
            pwr_r      <= pwr_nxt;
            rep_r      <= rep_nxt;
            pull_r     <= pull_nxt;
            dereg_r    <= dereg_nxt;
        end
    end

    // The stored function survives restart, as non-volatile storage would.
    always_ff @(posedge clk) begin
        fn_store_r <= fn_store_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign pins.host_wake_line = wake_r;
    assign pins.power_ind      = pwr_r;
    assign pins.pad_pullup_en  = pull_r;
    assign report_pulse        = rep_r;
    assign dereg_req           = dereg_r;
    assign pad_fn_active       = fn_act_r;
    assign powered_down        = pwr_r;

endmodule : hwfs_module

// file: src/hwfs_host.sv
`timescale 1ns/10ps

module hwfs_host #(
    parameter int unsigned QOFF_CYC = hwfs_pkg::QOFF_MIN_CYC // Low-time threshold in cycles.
) (
    input  wire logic  clk,          // 200 MHz clock.
    input  wire logic  srst,         // Synchronous reset, high.
    hwfs_if.host_end   pins,         // Pins toward the module.
    input  wire logic  req_off,      // Pulse: request fast shutdown.
    input  wire logic  power_on,     // Level: host wants power-on asserted.
    output logic       wake_seen,    // Pulse: wake request edge seen.
    output logic       module_off,   // Level: module reports power-down.
    output logic       busy          // Level: shutdown pulse in progress.
);
    import hwfs_pkg::*;

    logic              w1_r, w2_r, w3_r, p1_r, p2_r;
    logic              on_r, on_nxt, drv_r, drv_nxt, busy_r, busy_nxt, ws_r, ws_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            w1_r <= 1'h1;
            w2_r <= 1'h1;
            w3_r <= 1'h1;
            p1_r <= 1'h0;
            p2_r <= 1'h0;
        end else begin
            w1_r <= pins.host_wake_line;
            w2_r <= w1_r;
            w3_r <= w2_r;
            p1_r <= pins.power_ind;
            p2_r <= p1_r;
        end
    end

    // Hold the pad low for QOFF_CYC + 9 cycles, nine past the threshold, so the module sees >1 ms.
    always_comb begin
        on_nxt   = power_on && !p2_r;
        drv_nxt  = drv_r;
        busy_nxt = busy_r;
        cnt_nxt  = cnt_r;
        ws_nxt   = w3_r && !w2_r;
        if (p2_r) begin
            drv_nxt  = 1'h0;
            busy_nxt = 1'h0;
        end else if (!busy_r && req_off) begin
            busy_nxt = 1'h1;
            cnt_nxt  = '0;
            on_nxt   = 1'h0;
        end else if (busy_r && !drv_r) begin
            drv_nxt  = 1'h1;
        end else if (busy_r && cnt_r != CNT_W'(QOFF_CYC + 8)) begin
            cnt_nxt  = cnt_r + CNT_W'(1);
        end else if (busy_r) begin
            drv_nxt  = 1'h0;
            busy_nxt = 1'h0;
        end
        if (busy_r) begin
            on_nxt = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            on_r   <= 1'h0;
            drv_r  <= 1'h0;
            busy_r <= 1'h0;
            cnt_r  <= '0;
            ws_r   <= 1'h0;
        end else begin
            on_r   <= on_nxt;
            drv_r  <= drv_nxt;
            busy_r <= busy_nxt;
            cnt_r  <= cnt_nxt;
            ws_r   <= ws_nxt;
        end
    end

    // Pad is released (high impedance) when not pulsing; is host software policy.
    assign pins.on_line      = on_r;
    assign pins.quick_off_o  = 1'h0;
    assign pins.quick_off_oe = drv_r;
    assign wake_seen         = ws_r;
    assign module_off        = p2_r;
    assign busy              = busy_r;

endmodule : hwfs_host

// file: dv/hwfs_chk.sv
`timescale 1ns/10ps
// ************************************************************
// Pin checks between module end and host end
// ************************************************************
module hwfs_chk import hwfs_pkg::*; #(parameter int unsigned QOFF_CYC = QOFF_MIN_CYC) (
    input wire logic clk,            // Clock.
    input wire logic srst,           // Synchronous reset, high.
    input wire logic host_wake_line, // Wake request, low active.
    input wire logic power_ind,      // Power indication.
    input wire logic on_line,        // Power-on input.
    input wire logic quick_off_o,    // Host pad value.
    input wire logic quick_off_oe,   // Host pad enable.
    input wire logic pad_pullup_en,  // Module pull-up.
    input wire logic quick_off_line  // Resolved pad.
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic [19:0] low_r, low_nxt; // Cycles the pad has been low.
    logic [2:0]  run_r, run_nxt; // Cycles since reset release.
    // Both counters saturate, so a long stall cannot wrap into a pass.
    always_comb begin
        low_nxt = quick_off_line ? 20'h0 : low_r + {19'h0, ~&low_r};
        run_nxt = run_r + {2'h0, run_r != 3'h4};
        if (srst) begin
            low_nxt = 20'h0;
            run_nxt = 3'h0;
        end
    end
    // Counter registers.
    always_ff @(posedge clk) begin
        low_r <= low_nxt;
        run_r <= run_nxt;
    end
    a_off_sticky: assert property (power_ind |=> power_ind)
        else $error("power indication left the off state");
    a_wake_idle_off: assert property (power_ind |-> host_wake_line)
        else $error("wake request while powered down");
    a_on_first: assert property ($rose(quick_off_oe) |-> !$past(on_line))
        else $error("pad pulled low before power-on dropped");
    a_on_held: assert property (quick_off_oe |-> !on_line)
        else $error("power-on high while pad driven");
    a_pad_low_only: assert property (quick_off_oe |-> !quick_off_o)
        else $error("host drove the pad high");
    a_hold_long: assert property ($rose(quick_off_line) && $past(quick_off_oe)
        |-> low_r >= QOFF_CYC)
        else $error("shutdown pulse shorter than the minimum");
    a_pullup_fixed: assert property (run_r == 3'h4 |-> $stable(pad_pullup_en))
        else $error("pad function changed without restart");
    // The host needs two sync flops and one register to react to power_ind.
    a_off_lines_low: assert property (power_ind [*4] |-> !on_line)
        else $error("host kept power-on high while module off");
    c_off: cover property ($rose(power_ind));
    c_wake: cover property ($fell(host_wake_line));
    c_pad: cover property ($rose(quick_off_oe));
endmodule : hwfs_chk

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import hwfs_pkg::*;
    // Shortened low-time threshold keeps the run short; the ends default to 1 ms.
    localparam int unsigned TB_QOFF_CYC = 400;
    logic clk = 1'b0, srst = 1'b1, cfg_pad_fn_we = 1'b1, arm_quick_off = 1'b0;
    logic cmd_shutdown = 1'b0, cmd_fast = 1'b0, event_pending = 1'b0, host_awake = 1'b0;
    logic flash_busy = 1'b0, dereg_done = 1'b0, req_off = 1'b0, power_on = 1'b1;
    logic [1:0] cfg_pad_fn = 2'h1;
    logic [1:0] pad_fn_active;
    logic report_pulse, dereg_req, powered_down, wake_seen, module_off, busy;
    logic rep_seen, dereg_seen;
    int failures = 0, n_checks = 0, wakes = 0, i;
    hwfs_if pins_if ();
    hwfs_module #(.QOFF_CYC(TB_QOFF_CYC)) hwfs_module_inst (.clk, .srst, .pins(pins_if),
        .cfg_pad_fn, .cfg_pad_fn_we,
        .arm_quick_off, .cmd_shutdown, .cmd_fast, .event_pending, .host_awake, .flash_busy,
        .dereg_done, .report_pulse, .dereg_req, .pad_fn_active, .powered_down);
    hwfs_host #(.QOFF_CYC(TB_QOFF_CYC)) hwfs_host_inst (.clk, .srst, .pins(pins_if),
        .req_off, .power_on, .wake_seen,
        .module_off, .busy);
    hwfs_chk #(.QOFF_CYC(TB_QOFF_CYC)) hwfs_chk_inst (.clk, .srst,
        .host_wake_line(pins_if.host_wake_line),
        .power_ind(pins_if.power_ind), .on_line(pins_if.on_line),
        .quick_off_o(pins_if.quick_off_o), .quick_off_oe(pins_if.quick_off_oe),
        .pad_pullup_en(pins_if.pad_pullup_en), .quick_off_line(pins_if.quick_off_line));
    always #2.5 clk = ~clk;
    // One-cycle pulses are latched here so a check cannot miss them.
    always @(posedge clk) begin
        if (report_pulse === 1'b1) rep_seen <= 1'b1;
        if (dereg_req === 1'b1) dereg_seen <= 1'b1;
        if (wake_seen === 1'b1) wakes <= wakes + 1;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // A pulse input is high for exactly one clock.
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        cyc(1);
        sig = 1'b0;
    endtask : pulse
    task automatic restart();
        srst = 1'b1;
        cyc(16);
        srst = 1'b0;
        rep_seen = 1'b0;
        dereg_seen = 1'b0;
        cyc(3);
    endtask : restart
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // Watchdog sized for one full pad-held shutdown plus margin.
    initial begin
        repeat (8 * TB_QOFF_CYC + 2000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial begin
        restart();
        cfg_pad_fn_we = 1'b0;
        chk("fn_active", 2'h1, pad_fn_active);
        chk("pullup", 2'h1, {1'b0, pins_if.pad_pullup_en});
        chk("power_ind", 2'h0, {1'b0, pins_if.power_ind});
        host_awake = 1'b1;
        event_pending = 1'b1;
        cyc(3);
        chk("wake_awake", 2'h1, {1'b0, pins_if.host_wake_line});
        event_pending = 1'b0;
        host_awake = 1'b0;
        cyc(2);
        event_pending = 1'b1;
        cyc(1);
        chk("wake_low", 2'h0, {1'b0, pins_if.host_wake_line});
        event_pending = 1'b0;
        cyc(4);
        chk("wake_idle", 2'h1, {1'b0, pins_if.host_wake_line});
        chk("wake_seen", 2'h1, wakes[1:0]);
        flash_busy = 1'b1;
        pulse(arm_quick_off);
        pulse(req_off);
        cyc(3);
        chk("on_line", 2'h0, {1'b0, pins_if.on_line});
        i = 0;
        while (busy !== 1'b0 && i < TB_QOFF_CYC + 2000) begin
            cyc(1);
            i++;
        end
        chk("pulse_done", 2'h0, {1'b0, busy});
        cyc(8);
        chk("flushing", 2'h0, {1'b0, powered_down});
        flash_busy = 1'b0;
        cyc(6);
        chk("fast_off", 2'h1, {1'b0, powered_down});
        chk("no_dereg", 2'h0, {1'b0, dereg_seen});
        chk("ind_off", 2'h3, {pins_if.power_ind, module_off});
        restart();
        pulse(cmd_shutdown);
        cyc(4);
        chk("report", 2'h1, {1'b0, rep_seen});
        chk("dereg_wait", 2'h2, {dereg_seen, powered_down});
        dereg_done = 1'b1;
        cyc(4);
        chk("normal_off", 2'h1, {1'b0, powered_down});
        dereg_done = 1'b0;
        cfg_pad_fn = 2'h0;
        pulse(cfg_pad_fn_we);
        chk("fn_kept", 2'h1, pad_fn_active);
        restart();
        chk("fn_new", 2'h0, pad_fn_active);
        chk("no_pullup", 2'h0, {1'b0, pins_if.pad_pullup_en});
        cmd_fast = 1'b1;
        pulse(cmd_shutdown);
        cyc(6);
        chk("fast_cmd", 2'h1, {rep_seen, powered_down});
        chk("fast_dereg", 2'h0, {1'b0, dereg_seen});
        end_sim();
    end
endmodule : tb_top
